// ### tb.sv
/*
  self-checking bench of the serial channel control block.
  assumes uacr_core on classic wishbone and the remote line model.
*/
`include "uacr_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0; // 100 mhz
  logic rst_i = 1'b1; // synchronous, active high
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic tx;
  logic rx;
  logic irq;
  int n_fail = 0;
  int cmp_count = 0;
  always #5 clk_i = ~clk_i;
  uacr_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_i(rx),
    .tx_o(tx), .irq_o(irq));
  uacr_remote u_far (.clk_i(clk_i), .line_i(tx), .line_o(rx));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle; ack is sampled as it stood at the edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      $display("CHECK FAILED at %0t: no ack", $time);
      final_report();
    end
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i); // idle cycle between requests
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    wb(1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask
  // reset values, field widths, reserved bits, unmapped space
  task automatic t_regs();
    rd(`UACR_OFS_CTL, 16'h0000);
    rd(`UACR_OFS_FLAG, 16'h0001);
    rd(`UACR_OFS_INTE, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    wr(`UACR_OFS_BAUD, 16'hfa09);
    rd(`UACR_OFS_BAUD, 16'h0a09);
    wr(`UACR_OFS_MODE, 16'hff07);
    rd(`UACR_OFS_MODE, 16'h0007);
    wr(`UACR_OFS_INTE, 16'hffff);
    rd(`UACR_OFS_INTE, 16'h007f);
    wr(`UACR_OFS_INTE, 16'h0000);
    rd(8'h1c, 16'h0000);
    $display("register test done");
  endtask
  // one frame per mode: odd parity, two stops; no parity; even, one stop
  task automatic t_tx();
    logic [15:0] m [3] = '{16'h0007, 16'h0000, 16'h0004};
    logic [11:0] f;
    logic ok;
    for (int k = 0; k < 3; k++) begin
      wr(`UACR_OFS_CTL, 16'h0000);
      wr(`UACR_OFS_MODE, m[k]);
      wr(`UACR_OFS_CTL, 16'h0003);
      rd(`UACR_OFS_FLAG, 16'h0001);
      fork
        u_far.grab(f, ok);
        begin
          wr(`UACR_OFS_TXD, 16'h00a5);
          rd(`UACR_OFS_FLAG, 16'h0101);
          // just past a one-stop frame, inside a two-stop one
          repeat (108) @(posedge clk_i);
          rd(`UACR_OFS_FLAG, m[k][0] ? 16'h0101 : 16'h0041);
        end
      join
      chk({3'h0, ok, f},
          {4'h1, 2'b11, (m[k][2] ? m[k][1] : 1'b1), 8'ha5, 1'b0});
      rd(`UACR_OFS_FLAG, 16'h0041);
      wr(`UACR_OFS_FLAG, 16'h0040);
      rd(`UACR_OFS_FLAG, 16'h0001);
    end
    $display("transmit test done");
  endtask
  // disabled unit, fifo order, flag clearing, errors, irq, soft reset
  task automatic t_rx();
    wr(`UACR_OFS_CTL, 16'h0000);
    wr(`UACR_OFS_TXD, 16'h0055);
    repeat (40) @(posedge clk_i);
    chk({15'h0, tx}, 16'h0001);
    rd(`UACR_OFS_FLAG, 16'h0000);
    wr(`UACR_OFS_CTL, 16'h0003);
    repeat (150) @(posedge clk_i); // let any held byte drain
    wr(`UACR_OFS_FLAG, 16'h0040);
    rd(`UACR_OFS_FLAG, 16'h0001);
    fork
      u_far.send(8'h3c, 1'b0, 1'b1);
      begin
        repeat (40) @(posedge clk_i);
        rd(`UACR_OFS_FLAG, 16'h0201);
      end
    join
    u_far.send(8'hc1, 1'b1, 1'b1);
    rd(`UACR_OFS_FLAG, 16'h0007);
    rd(`UACR_OFS_RXD, 16'h003c);
    rd(`UACR_OFS_FLAG, 16'h0007);
    rd(`UACR_OFS_RXD, 16'h00c1);
    rd(`UACR_OFS_FLAG, 16'h0001);
    u_far.send(8'h3c, 1'b1, 1'b1); // wrong even parity
    rd(`UACR_OFS_FLAG, 16'h0013);
    rd(`UACR_OFS_RXD, 16'h003c);
    rd(`UACR_OFS_FLAG, 16'h0001);
    u_far.send(8'h3c, 1'b0, 1'b0); // stop bit low
    rd(`UACR_OFS_FLAG, 16'h0023);
    wr(`UACR_OFS_FLAG, 16'h0020);
    rd(`UACR_OFS_FLAG, 16'h0003);
    u_far.send(8'h11, 1'b0, 1'b1);
    u_far.send(8'h22, 1'b0, 1'b1); // third byte overruns
    rd(`UACR_OFS_FLAG, 16'h000f);
    wr(`UACR_OFS_FLAG, 16'h0000);
    rd(`UACR_OFS_FLAG, 16'h000f);
    wr(`UACR_OFS_FLAG, 16'h0008);
    rd(`UACR_OFS_FLAG, 16'h0007);
    wr(`UACR_OFS_INTE, 16'h0004);
    chk({15'h0, irq}, 16'h0001);
    wr(`UACR_OFS_INTE, 16'h0008);
    chk({15'h0, irq}, 16'h0000);
    wr(`UACR_OFS_CTL, 16'h0003);
    rd(`UACR_OFS_FLAG, 16'h0001);
    rd(`UACR_OFS_CTL, 16'h0001);
    $display("receive test done");
  endtask
  // hardware reset in mid-run must bring back the reset value of every register but TXD and RXD
  task automatic t_rst();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({15'h0, tx}, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    rd(`UACR_OFS_BAUD, 16'h0000);
    rd(`UACR_OFS_MODE, 16'h0000);
    rd(`UACR_OFS_CTL, 16'h0000);
    rd(`UACR_OFS_INTE, 16'h0000);
    rd(`UACR_OFS_FLAG, 16'h0001);
    $display("reset test done");
  endtask
  // reset for eight cycles, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_tx();
    t_rx();
    t_rst();
    final_report();
  end
endmodule

// ### uacr_core.sv
/*
  control and status registers plus a minimal frame engine of one
  asynchronous serial channel, reached over classic wishbone.
  assumes rx_i is asynchronous and clk_i runs at 100 mhz.
*/
`include "uacr_map.svh"
module uacr_core #(
  parameter int unsigned ADR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic irq_o
);
  import uacr_pkg::*;

  // refuse address widths that cannot reach the map
  if (ADR_W < 8) begin : g_chk
    $error("ADR_W must be at least 8");
  end

  // parity bit: even parity is plain xor, odd inverts it
  function automatic logic par_bit(uacr_byte_t d, logic odd);
    par_bit = (^d) ^ odd;
  endfunction

  // bus decode
  logic ack_ff; // registered acknowledge
  logic [31:0] dat_ff; // registered read data
  logic req; // new access this cycle
  logic wr_lo; // write on byte lane 0
  logic wr_hi; // write on byte lane 1
  logic rd;
  logic [7:0] ofs;
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_lo = req & wb_we_i & wb_sel_i[0];
  assign wr_hi = req & wb_we_i & wb_sel_i[1];
  assign rd = req & ~wb_we_i;
  assign ofs = wb_adr_i[7:0];
  wire hit_mode = ofs == `UACR_OFS_MODE;
  wire hit_baud = ofs == `UACR_OFS_BAUD;
  wire hit_ctl = ofs == `UACR_OFS_CTL;
  wire hit_txd = ofs == `UACR_OFS_TXD;
  wire hit_rxd = ofs == `UACR_OFS_RXD;
  wire hit_flag = ofs == `UACR_OFS_FLAG;
  wire hit_inte = ofs == `UACR_OFS_INTE;

  // software state
  logic [2:0] mode_ff; // parity on, odd, two stops
  logic [3:0] fine_ff; // baud fine adjust, stored only
  logic [7:0] div_ff; // baud divisor
  logic en_ff; // unit enable
  logic srst_ff; // soft reset in progress
  logic [6:0] inte_ff; // interrupt enables
  logic [6:1] flg_ff; // sticky causes, bit 0 lives in tbuf
  uacr_byte_t tbuf_ff; // transmit buffer
  logic tfull_ff; // transmit buffer holds a byte
  // mode and baud are written freely; keeping them still while
  // enabled is left to software, the hardware does not lock them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= 3'h0;
      fine_ff <= 4'h0;
      div_ff <= 8'h00;
      en_ff <= 1'b0;
      inte_ff <= 7'h00;
    end else begin
      if (wr_lo && hit_mode) mode_ff <= wb_dat_i[2:0];
      if (wr_lo && hit_baud) div_ff <= wb_dat_i[7:0];
      if (wr_hi && hit_baud) fine_ff <= wb_dat_i[11:8];
      if (wr_lo && hit_ctl) en_ff <= wb_dat_i[`UACR_CTL_EN];
      if (wr_lo && hit_inte) inte_ff <= wb_dat_i[6:0];
    end
  end

  // soft reset lasts one cycle; a zero write does nothing
  always_ff @(posedge clk_i) begin
    srst_ff <= ~rst_i & wr_lo & hit_ctl & wb_dat_i[`UACR_CTL_SRST];
  end
  wire eng_rst = rst_i | srst_ff;

  // baud tick for the sender; fine adjust is not applied here
  logic [7:0] tcnt_ff;
  logic tload; // byte moves from buffer to shifter
  wire ttick = en_ff & (tcnt_ff == div_ff);
  always_ff @(posedge clk_i) begin
    if (eng_rst || tload || ttick) begin
      tcnt_ff <= 8'h00;
    end else if (en_ff) begin
      tcnt_ff <= tcnt_ff + 8'h01;
    end
  end

  // sender
  uacr_phase_t tst_ff;
  uacr_byte_t tsh_ff; // shifting copy
  uacr_byte_t tbyte_ff; // whole byte, for the parity bit
  logic [2:0] tbit_ff;
  logic tstop_ff; // second stop pending
  logic txd_ff;
  logic tend; // last stop bit finished
  assign tload = en_ff & (tst_ff == UACR_IDLE) & tfull_ff;
  assign tend = ttick & (tst_ff == UACR_STOP) & ~tstop_ff;
  always_ff @(posedge clk_i) begin
    if (eng_rst) begin
      tst_ff <= UACR_IDLE;
      tsh_ff <= 8'h00;
      tbyte_ff <= 8'h00;
      tbit_ff <= 3'h0;
      tstop_ff <= 1'b0;
      txd_ff <= 1'b1;
    end else if (tload) begin
      tst_ff <= UACR_START;
      tsh_ff <= tbuf_ff;
      tbyte_ff <= tbuf_ff;
      txd_ff <= 1'b0;
    end else if (ttick) begin
      unique case (tst_ff)
        UACR_IDLE: begin
          txd_ff <= 1'b1;
        end
        UACR_START: begin
          tst_ff <= UACR_DATA;
          tbit_ff <= 3'h0;
          txd_ff <= tsh_ff[0];
        end
        UACR_DATA: begin
          tsh_ff <= {1'b0, tsh_ff[7:1]};
          tbit_ff <= tbit_ff + 3'h1;
          if (tbit_ff == 3'h7) begin
            // parity slot only when the function is on
            if (mode_ff[`UACR_MODE_PAR_ON]) begin
              tst_ff <= UACR_PAR;
              txd_ff <= par_bit(tbyte_ff, mode_ff[`UACR_MODE_ODD]);
            end else begin
              tst_ff <= UACR_STOP;
              tstop_ff <= mode_ff[`UACR_MODE_STOP2];
              txd_ff <= 1'b1;
            end
          end else begin
            txd_ff <= tsh_ff[1];
          end
        end
        UACR_PAR: begin
          tst_ff <= UACR_STOP;
          tstop_ff <= mode_ff[`UACR_MODE_STOP2];
          txd_ff <= 1'b1;
        end
        UACR_STOP: begin
          // second stop bit when two are selected
          if (tstop_ff) begin
            tstop_ff <= 1'b0;
          end else begin
            tst_ff <= UACR_IDLE;
          end
        end
      endcase
    end
  end

  // transmit buffer: a write refills it even if a move is due
  wire twr = wr_lo & hit_txd;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbuf_ff <= 8'h00;
    end else if (twr) begin
      tbuf_ff <= wb_dat_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (eng_rst) begin
      tfull_ff <= 1'b0;
    end else if (twr) begin
      tfull_ff <= 1'b1;
    end else if (tload) begin
      tfull_ff <= 1'b0;
    end
  end

  // receive pin: three stages, a change counts when two agree
  logic [2:0] rsync_ff;
  logic rlvl_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsync_ff <= 3'h7;
      rlvl_ff <= 1'b1;
    end else begin
      rsync_ff <= {rsync_ff[1:0], rx_i};
      if (rsync_ff[1] == rsync_ff[2]) begin
        rlvl_ff <= rsync_ff[2];
      end
    end
  end

  // receiver: counter starts half a bit in, sampling mid-bit
  uacr_phase_t rst_ff;
  logic [7:0] rcnt_ff;
  uacr_byte_t rsh_ff;
  logic [2:0] rbit_ff;
  logic perr_ff;
  logic rpush; // frame complete, byte offered to fifo
  logic ferr; // stop bit seen low
  wire rtick = en_ff & (rcnt_ff == div_ff);
  assign rpush = rtick & (rst_ff == UACR_STOP);
  assign ferr = ~rlvl_ff;
  always_ff @(posedge clk_i) begin
    if (eng_rst) begin
      rst_ff <= UACR_IDLE;
      rcnt_ff <= 8'h00;
      rsh_ff <= 8'h00;
      rbit_ff <= 3'h0;
      perr_ff <= 1'b0;
    end else if (en_ff) begin
      rcnt_ff <= rtick ? 8'h00 : rcnt_ff + 8'h01;
      unique case (rst_ff)
        UACR_IDLE: begin
          if (!rlvl_ff) begin
            rst_ff <= UACR_START;
            rcnt_ff <= {1'b0, div_ff[7:1]};
            perr_ff <= 1'b0;
          end
        end
        UACR_START: begin
          // a start bit gone high by mid-bit was a glitch
          if (rtick) begin
            rst_ff <= rlvl_ff ? UACR_IDLE : UACR_DATA;
            rbit_ff <= 3'h0;
          end
        end
        UACR_DATA: begin
          if (rtick) begin
            rsh_ff <= {rlvl_ff, rsh_ff[7:1]};
            rbit_ff <= rbit_ff + 3'h1;
            if (rbit_ff == 3'h7) begin
              rst_ff <= mode_ff[`UACR_MODE_PAR_ON] ? UACR_PAR : UACR_STOP;
            end
          end
        end
        UACR_PAR: begin
          if (rtick) begin
            perr_ff <= rlvl_ff != par_bit(rsh_ff, mode_ff[`UACR_MODE_ODD]);
            rst_ff <= UACR_STOP;
          end
        end
        UACR_STOP: begin
          // only the first stop bit is checked
          if (rtick) begin
            rst_ff <= UACR_IDLE;
          end
        end
      endcase
    end
  end

  // two-entry fifo, entry 0 oldest
  uacr_byte_t rmem_ff [2];
  logic [1:0] rcnt_q_ff; // bytes held
  wire rrd = rd & hit_rxd;
  wire pop = rrd & (rcnt_q_ff != 2'h0);
  wire full = rcnt_q_ff == `UACR_RX_DEPTH;
  wire push = rpush & (~full | pop);
  wire [1:0] widx = rcnt_q_ff - {1'b0, pop};
  always_ff @(posedge clk_i) begin
    if (eng_rst) begin
      rcnt_q_ff <= 2'h0;
    end else begin
      rcnt_q_ff <= widx + {1'b0, push};
    end
  end
  always_ff @(posedge clk_i) begin
    if (pop) begin
      rmem_ff[0] <= rmem_ff[1];
    end
    if (push) begin
      rmem_ff[widx[0]] <= rsh_ff;
    end
  end

  // cause flags: set wins over any clear in the same cycle
  wire [6:1] fset = {tend & ~tfull_ff, push & ferr, push & perr_ff,
                     rpush & full & ~pop, push & (widx == 2'h1),
                     push & (widx == 2'h0)};
  wire wr_flag = wr_lo & hit_flag;
  // only the writable causes take a write of one as a clear
  wire [6:0] w1c = wr_flag ? wb_dat_i[6:0] & `UACR_W1C_MASK : 7'h00;
  wire [6:1] rclr = {1'b0, rrd, rrd, 1'b0, pop & (rcnt_q_ff == 2'h1),
                     pop & (rcnt_q_ff == 2'h1)};
  wire [6:1] nxt_flg = fset | (flg_ff & ~(w1c[6:1] | rclr));
  always_ff @(posedge clk_i) begin
    if (eng_rst) begin
      flg_ff <= 6'h00;
    end else begin
      flg_ff <= nxt_flg;
    end
  end
  wire [6:0] flags = {flg_ff, ~tfull_ff};
  wire tx_act = tst_ff != UACR_IDLE;
  wire rx_act = rst_ff != UACR_IDLE;

  // read mux, 16-bit registers in the low half
  wire [15:0] rmux =
      hit_mode ? {13'h0000, mode_ff} :
      hit_baud ? {4'h0, fine_ff, div_ff} :
      hit_ctl ? {14'h0000, srst_ff, en_ff} :
      hit_txd ? {8'h00, tbuf_ff} :
      hit_rxd ? {8'h00, rmem_ff[0]} :
      hit_flag ? {6'h00, rx_act, tx_act, 1'b0, flags} :
      hit_inte ? {9'h000, inte_ff} : 16'h0000;
  // unmapped offsets still answer, with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (rd) begin
        dat_ff <= {16'h0000, rmux};
      end
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign tx_o = txd_ff;
  assign irq_o = |(flags & inte_ff);

  // checks
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_ff |=> !ack_ff) else $error("ack held two cycles");
  srst_self_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lo && hit_ctl && wb_dat_i[1]) |=> srst_ff ##1 !srst_ff)
    else $error("soft reset bit did not self clear");
  srst_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    srst_ff |=> flags == `UACR_FLG_RST && !tx_act && !rx_act)
    else $error("soft reset left state behind");
  tbe_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    twr |=> !flags[0]) else $error("buffer empty not cleared");
  stop_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tst_ff == UACR_STOP) |-> tx_o) else $error("stop bit low");
  par_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tst_ff == UACR_PAR) |-> tx_o == ((^tbyte_ff) ^ mode_ff[1]))
    else $error("wrong parity bit");
  fifo_depth_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rcnt_q_ff <= 2'h2) else $error("fifo over depth");
  err_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rrd && !rpush && !srst_ff) |=> !flg_ff[5] && !flg_ff[4])
    else $error("error flags survived read");
  rb_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pop && rcnt_q_ff == 2'h1 && !rpush) |=> flg_ff[2:1] == 2'h0)
    else $error("byte count flags not cleared");
  irq_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> $past(|flags) || |flags)
    else $error("interrupt without cause");
  hold_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!en_ff && !srst_ff) |=> $stable(tst_ff) && $stable(rst_ff))
    else $error("engine moved while disabled");
  resv_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_dat_o[31:16] == 16'h0000) else $error("upper data not zero");
endmodule

// ### uacr_map.svh
/*
  register offsets, field positions, reset values and fifo depth of
  the serial channel control block.
  assumes a wishbone slave with 32-bit data and byte addresses.
*/
`ifndef UACR_MAP_SVH
`define UACR_MAP_SVH
`define UACR_OFS_MODE 8'h00
`define UACR_OFS_BAUD 8'h04
`define UACR_OFS_CTL 8'h08
`define UACR_OFS_TXD 8'h0c
`define UACR_OFS_RXD 8'h10
`define UACR_OFS_FLAG 8'h14
`define UACR_OFS_INTE 8'h18
`define UACR_MODE_PAR_ON 2
`define UACR_MODE_ODD 1
`define UACR_MODE_STOP2 0
`define UACR_CTL_SRST 1
`define UACR_CTL_EN 0
`define UACR_FLG_TEND 6
`define UACR_FLG_FE 5
`define UACR_FLG_PE 4
`define UACR_FLG_OE 3
`define UACR_FLG_RB2 2
`define UACR_FLG_RB1 1
`define UACR_FLG_TBE 0
`define UACR_ST_RXACT 9
`define UACR_ST_TXACT 8
`define UACR_W1C_MASK 7'h78
`define UACR_FLG_RST 7'h01
`define UACR_RX_DEPTH 2'h2
`endif

// ### uacr_pkg.sv
/*
  types of the serial channel control block.
  assumes the map header supplies the register numbers; phase codes and byte width are set here.
*/
package uacr_pkg;
  // frame phase shared by sender and receiver
  typedef enum logic [2:0] {
    UACR_IDLE = 3'b000,
    UACR_START = 3'b001,
    UACR_DATA = 3'b010,
    UACR_PAR = 3'b011,
    UACR_STOP = 3'b100
  } uacr_phase_t;
  typedef logic [7:0] uacr_byte_t;
endpackage

// ### uacr_remote.sv
/*
  line-side model of the remote serial transceiver.
  assumes frames of start, 8 data bits lsb first, parity, stop.
*/
module uacr_remote #(
  parameter int BIT_CYC = 10 // divisor 9 gives ten clocks a bit
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1; // line idles high, always driven
  // send one frame; a wrong parity or stop level is the caller's choice
  task automatic send(input logic [7:0] d, input logic par, input logic stp);
    logic [10:0] f;
    f = {stp, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    line_o <= 1'b1;
    // one idle bit keeps frames apart
    repeat (BIT_CYC) @(posedge clk_i);
  endtask
  // capture twelve bit times from a falling start edge, bounded wait
  task automatic grab(output logic [11:0] f, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 4000 && !ok; n++) begin
      @(posedge clk_i);
      ok = (line_i === 1'b0);
    end
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 12; i++) begin
      f[i] = line_i;
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask
endmodule
